// ---- mipv_cfg.svh ----
// Offsets, reset values and vector addresses of the interrupt resolver
`ifndef MIPV_CFG_SVH
`define MIPV_CFG_SVH
`define MIPV_OFF_PROMO      3'h0
`define MIPV_OFF_OPTION     3'h1
`define MIPV_OFF_ENA0       3'h2
`define MIPV_OFF_ENA1       3'h3
`define MIPV_OFF_ENA2       3'h4
`define MIPV_OFF_STATUS     3'h5
`define MIPV_PROMO_RST      4'h5
`define MIPV_CME_BIT        0
`define MIPV_VEC_RESET      16'hFFFE
`define MIPV_VEC_CLKMON     16'hFFFC
`define MIPV_VEC_WDOG       16'hFFFA
`define MIPV_VEC_ILLEGAL    16'hFFF8
`define MIPV_VEC_TRAP       16'hFFF6
`define MIPV_VEC_XPIN       16'hFFF4
`define MIPV_VEC_SLOT0      16'hFFF2
`define MIPV_VEC_STEP       16'h0002
`endif

// ---- mipv_pkg.sv ----
// Types shared by the interrupt resolver
package mipv_pkg;
    `include "mipv_cfg.svh"
    typedef enum logic [2:0] {
        MIPV_IDLE,
        MIPV_STACK,
        MIPV_FETCH_HI,
        MIPV_FETCH_LO,
        MIPV_LOAD
    } mipv_state_type;
    typedef struct packed {
        mipv_state_type st;
        logic           x_flag;
        logic           i_flag;
        logic           xsvc;
        logic [3:0]     promo;
        logic           clock_watch_enable;
        logic [5:0]     ena0;
        logic [7:0]     ena1;
        logic [3:0]     ena2;
        logic           ill_pend;
        logic [15:0]    vec;
        logic [15:0]    pc;
        logic [15:0]    mem_addr;
        logic           mem_rd;
        logic           pc_load;
        logic           take;
        logic           trap_ok;
        logic [7:0]     rdata;
    } mipv_regs_type;
endpackage

// ---- mipv_ctrl.sv ----
// Interrupt collection, masking, priority resolution and vector fetch
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "mipv_cfg.svh"
module mipv_ctrl
#(
    parameter int ADDR_W = 3
)
(
    input  wire logic              clock_i,
    input  wire logic              resetn_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    input  wire logic              instr_boundary_i,
    input  wire logic              soft_trap_instr_i,
    input  wire logic              illegal_opcode_i,
    input  wire logic              ccr_stacked_i,
    input  wire logic              tap_i,
    input  wire logic              tap_x_i,
    input  wire logic              tap_i_flag_i,
    input  wire logic              return_from_trap_instr_i,
    input  wire logic              rtn_x_i,
    input  wire logic              rtn_i_flag_i,
    input  wire logic              clock_fail_i,
    input  wire logic              watchdog_fail_i,
    input  wire logic              watchdog_disable_cfg_i,
    input  wire logic              pseudo_nmi_pin_n_i,
    input  wire logic              irq_pin_n_i,
    input  wire logic              handshake_req_i,
    input  wire logic              periodic_req_i,
    input  wire logic [2:0]        capture_req_i,
    input  wire logic [4:0]        compare_req_i,
    input  wire logic              timer_wrap_req_i,
    input  wire logic              pulse_overflow_req_i,
    input  wire logic              pulse_edge_req_i,
    input  wire logic              serial_periph_req_i,
    input  wire logic              rx_full_req_i,
    input  wire logic              rx_overrun_req_i,
    input  wire logic              idle_line_req_i,
    input  wire logic              tx_empty_req_i,
    input  wire logic              tx_done_req_i,
    input  wire logic [7:0]        mem_data_i,
    output logic      [15:0]       mem_addr_o,
    output logic                   mem_rd_o,
    output logic      [15:0]       pc_o,
    output logic                   pc_load_o,
    output logic                   take_o,
    output logic      [15:0]       vector_addr_o,
    output logic                   trap_fetch_ok_o,
    output logic                   x_flag_o,
    output logic                   i_flag_o
);
    localparam int NSLOT = 15;

    mipv_pkg::mipv_regs_type s, n;
    logic [NSLOT-1:0] raw;
    logic [NSLOT-1:0] lena;
    logic [NSLOT-1:0] mreq;
    logic             sci_req;
    logic             xpin_req;
    logic             cm_fail;
    logic             wd_fail;
    logic [3:0]       pk;
    logic [3:0]       win;
    logic             any_i;

    if (ADDR_W < 3)
    begin : g_chk
        $error("mipv_ctrl: ADDR_W must be at least 3");
    end

    // Promotion code to slot index; slot k sits at FFF2 minus 2k
    function automatic logic [3:0] promo_slot(input logic [3:0] c);
        unique case (c)
            4'h0: promo_slot = 4'hA;
            4'h1: promo_slot = 4'hB;
            4'h2: promo_slot = 4'hC;
            4'h3: promo_slot = 4'hD;
            4'h4: promo_slot = 4'hE;
            4'h5: promo_slot = 4'h0;
            4'h6: promo_slot = 4'h0;
            4'h7: promo_slot = 4'h1;
            default: promo_slot = c - 4'h6;
        endcase
    endfunction

    // Asynchronous serial causes merged onto one slot
    assign sci_req = ((rx_full_req_i | rx_overrun_req_i) & s.ena2[0])
                   | (idle_line_req_i & s.ena2[1])
                   | (tx_empty_req_i & s.ena2[2])
                   | (tx_done_req_i & s.ena2[3]);

    // Slot order: pin/handshake, periodic, captures, compares, lower group
    assign raw = {sci_req, serial_periph_req_i, pulse_edge_req_i,
                  pulse_overflow_req_i, timer_wrap_req_i, compare_req_i,
                  capture_req_i, periodic_req_i,
                  (!irq_pin_n_i) | (handshake_req_i & s.ena0[5])};
    assign lena = {1'b1, s.ena0[3], s.ena0[2], s.ena0[1], s.ena0[0],
                   s.ena1[7:3], s.ena1[2:0], s.ena0[4], 1'b1};

    for (genvar k = 0; k < NSLOT; k++)
    begin : g_slot
        assign mreq[k] = raw[k] & lena[k] & !s.i_flag;
    end

    assign xpin_req = !pseudo_nmi_pin_n_i && !s.x_flag;
    assign cm_fail  = clock_fail_i && s.clock_watch_enable;
    assign wd_fail  = watchdog_fail_i && !watchdog_disable_cfg_i;
    assign pk       = promo_slot(s.promo);
    assign any_i    = |mreq;

    always_comb
    begin
        win = 4'h0;
        for (int k = NSLOT - 1; k >= 0; k--)
        begin
            if (mreq[k])
            begin
                win = 4'(k);
            end
        end
        if (mreq[pk])
        begin
            win = pk;
        end
    end

    always_comb
    begin
        n = s;
        n.take    = 1'b0;
        n.pc_load = 1'b0;
        n.mem_rd  = 1'b0;
        n.rdata   = 8'h00;
        if (illegal_opcode_i)
        begin
            n.ill_pend = 1'b1;
        end
        if (wr_i)
        begin
            unique case (addr_i[2:0])
                `MIPV_OFF_PROMO:
                    if (s.i_flag)
                    begin
                        n.promo = wdata_i[3:0];
                    end
                `MIPV_OFF_OPTION: n.clock_watch_enable = wdata_i[`MIPV_CME_BIT];
                `MIPV_OFF_ENA0: n.ena0 = wdata_i[5:0];
                `MIPV_OFF_ENA1: n.ena1 = wdata_i;
                `MIPV_OFF_ENA2: n.ena2 = wdata_i[3:0];
                default: ;
            endcase
        end
        if (rd_i)
        begin
            unique case (addr_i[2:0])
                `MIPV_OFF_PROMO:  n.rdata = {4'h0, s.promo};
                `MIPV_OFF_OPTION: n.rdata = {7'h00, s.clock_watch_enable};
                `MIPV_OFF_ENA0:   n.rdata = {2'h0, s.ena0};
                `MIPV_OFF_ENA1:   n.rdata = s.ena1;
                `MIPV_OFF_ENA2:   n.rdata = {4'h0, s.ena2};
                `MIPV_OFF_STATUS: n.rdata = {4'h0, s.st != mipv_pkg::MIPV_IDLE,
                                             s.ill_pend, s.i_flag, s.x_flag};
                default:          n.rdata = 8'h00;
            endcase
        end
        unique case (s.st)
            mipv_pkg::MIPV_IDLE:
            begin
                if (soft_trap_instr_i)
                begin
                    n.take = 1'b1;
                    n.xsvc = 1'b0;
                    n.vec  = `MIPV_VEC_TRAP;
                    n.st   = mipv_pkg::MIPV_STACK;
                end
                else if (instr_boundary_i &&
                         (s.ill_pend || xpin_req || any_i))
                begin
                    n.take = 1'b1;
                    n.xsvc = 1'b0;
                    n.st   = mipv_pkg::MIPV_STACK;
                    if (s.ill_pend)
                    begin
                        n.vec      = `MIPV_VEC_ILLEGAL;
                        n.ill_pend = illegal_opcode_i;
                    end
                    else if (xpin_req)
                    begin
                        n.vec  = `MIPV_VEC_XPIN;
                        n.xsvc = 1'b1;
                    end
                    else
                    begin
                        n.vec = `MIPV_VEC_SLOT0 -
                                16'({win, 1'b0});
                    end
                end
                else if (return_from_trap_instr_i)
                begin
                    n.x_flag = rtn_x_i;
                    n.i_flag = rtn_i_flag_i;
                end
                else if (tap_i)
                begin
                    n.x_flag = s.x_flag & tap_x_i;
                    n.i_flag = tap_i_flag_i;
                end
            end
            mipv_pkg::MIPV_STACK:
                if (ccr_stacked_i)
                begin
                    n.i_flag = 1'b1;
                    n.x_flag = s.x_flag | s.xsvc;
                    n.st     = mipv_pkg::MIPV_FETCH_HI;
                    n.mem_rd = 1'b1;
                    n.mem_addr = s.vec;
                end
            mipv_pkg::MIPV_FETCH_HI:
            begin
                n.st       = mipv_pkg::MIPV_FETCH_LO;
                n.mem_rd   = 1'b1;
                n.mem_addr = s.vec | 16'h0001;
            end
            mipv_pkg::MIPV_FETCH_LO:
            begin
                n.pc[15:8] = mem_data_i;
                n.st       = mipv_pkg::MIPV_LOAD;
            end
            mipv_pkg::MIPV_LOAD:
            begin
                n.pc[7:0] = mem_data_i;
                n.pc_load = 1'b1;
                n.st      = mipv_pkg::MIPV_IDLE;
            end
        endcase
        // Reset-class failures preempt any sequence, no stacking
        if (cm_fail || wd_fail)
        begin
            n.vec      = cm_fail ? `MIPV_VEC_CLKMON : `MIPV_VEC_WDOG;
            n.x_flag   = 1'b1;
            n.i_flag   = 1'b1;
            n.clock_watch_enable      = 1'b0;
            n.promo    = `MIPV_PROMO_RST;
            n.ill_pend = illegal_opcode_i;
            n.take     = 1'b0;
            n.pc_load  = 1'b0;
            n.st       = mipv_pkg::MIPV_FETCH_HI;
            n.mem_rd   = 1'b1;
            n.mem_addr = n.vec;
        end
        // Trap fetch allowed only with nothing else pending
        n.trap_ok = !(n.ill_pend || xpin_req || any_i) &&
                    n.st == mipv_pkg::MIPV_IDLE;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s          <= '0;
            s.st       <= mipv_pkg::MIPV_FETCH_HI;
            s.x_flag   <= 1'b1;
            s.i_flag   <= 1'b1;
            s.promo    <= `MIPV_PROMO_RST;
            s.vec      <= `MIPV_VEC_RESET;
            s.mem_addr <= `MIPV_VEC_RESET;
            s.mem_rd   <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    assign rdata_o         = s.rdata;
    assign mem_addr_o      = s.mem_addr;
    assign mem_rd_o        = s.mem_rd;
    assign pc_o            = s.pc;
    assign pc_load_o       = s.pc_load;
    assign take_o          = s.take;
    assign vector_addr_o   = s.vec;
    assign trap_fetch_ok_o = s.trap_ok;
    assign x_flag_o        = s.x_flag;
    assign i_flag_o        = s.i_flag;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    property p_wait_boundary;
        take_o |-> $past(instr_boundary_i) || $past(soft_trap_instr_i);
    endproperty
    a_wait_boundary: assert property (p_wait_boundary)
        else $error("request taken off an instruction boundary");

    property p_i_service;
        ($past(s.st) == mipv_pkg::MIPV_STACK && !$past(s.xsvc) &&
         !$past(cm_fail) && !$past(wd_fail) &&
         s.st == mipv_pkg::MIPV_FETCH_HI) |-> i_flag_o &&
        x_flag_o == $past(x_flag_o);
    endproperty
    a_i_service: assert property (p_i_service)
        else $error("I service flag update wrong");

    property p_x_service;
        ($past(s.st) == mipv_pkg::MIPV_STACK && $past(s.xsvc) &&
         s.st == mipv_pkg::MIPV_FETCH_HI) |-> i_flag_o && x_flag_o;
    endproperty
    a_x_service: assert property (p_x_service)
        else $error("pseudo-NMI service did not set both flags");

    property p_x_stays;
        (tap_i && !x_flag_o && s.st == mipv_pkg::MIPV_IDLE &&
         !return_from_trap_instr_i && !cm_fail && !wd_fail) |=> !x_flag_o;
    endproperty
    a_x_stays: assert property (p_x_stays)
        else $error("software set the X flag again");

    property p_promo_lock;
        (wr_i && addr_i[2:0] == `MIPV_OFF_PROMO && !i_flag_o &&
         !cm_fail && !wd_fail) |=> $stable(s.promo);
    endproperty
    a_promo_lock: assert property (p_promo_lock)
        else $error("promotion code written with I flag clear");

    property p_vec_bytes;
        pc_load_o |-> pc_o == {$past(mem_data_i, 2), $past(mem_data_i)};
    endproperty
    a_vec_bytes: assert property (p_vec_bytes)
        else $error("program counter not loaded from vector bytes");

    property p_trap_block;
        (take_o && vector_addr_o == `MIPV_VEC_TRAP) |=> !take_o [*4];
    endproperty
    a_trap_block: assert property (p_trap_block)
        else $error("interrupt honoured during trap vector fetch");

    property p_promoted;
        (take_o && $past(mreq[pk]) && !$past(s.ill_pend) &&
         !$past(xpin_req) && !$past(soft_trap_instr_i)) |->
        vector_addr_o == `MIPV_VEC_SLOT0 - 16'({$past(pk), 1'b0});
    endproperty
    a_promoted: assert property (p_promoted)
        else $error("promoted source not served first at its own vector");

    property p_illegal_first;
        (take_o && $past(s.ill_pend) && !$past(soft_trap_instr_i)) |->
        vector_addr_o == `MIPV_VEC_ILLEGAL;
    endproperty
    a_illegal_first: assert property (p_illegal_first)
        else $error("illegal opcode not served ahead of lower sources");
endmodule

// ---- mipv_core_model.sv ----
// Behavioural core and vector memory facing the interrupt resolver
`timescale 1ns/10ps
module mipv_core_model
(
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic        take_i,
    input  wire logic        mem_rd_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic [1:0]  stall_i,
    output logic             ccr_stacked_o,
    output logic      [7:0]  mem_data_o
);
    logic       pend_q;
    logic [1:0] wait_q;

    // Stacking time varies, so the resolver must not assume a count
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pend_q        <= 1'b0;
            wait_q        <= 2'h0;
            ccr_stacked_o <= 1'b0;
        end
        else
        begin
            ccr_stacked_o <= 1'b0;
            if (take_i)
            begin
                pend_q <= 1'b1;
                wait_q <= stall_i;
            end
            else if (pend_q && wait_q == 2'h0)
            begin
                pend_q        <= 1'b0;
                ccr_stacked_o <= 1'b1;
            end
            else if (pend_q)
                wait_q <= wait_q - 2'h1;
        end
    end

    // Idle bus toggles so a stale byte is never mistaken for data
    always_ff @(posedge clock_i)
    begin
        if (mem_rd_i)
            mem_data_o <= mem_addr_i[7:0] ^ 8'h5A;
        else
            mem_data_o <= ~mem_data_o;
    end
endmodule

// ---- mipv_ctrl_tb.sv ----
// Self-checking bench of the interrupt resolver
`timescale 1ns/10ps
module mipv_ctrl_tb;
`define CHK(n, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            err_total++; \
            $display("ERROR %s exp %0h got %0h", n, e, g); \
        end \
    end
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        bnd = 1'b0, trap = 1'b0, ill = 1'b0, condition_code_reg;
    logic        tap = 1'b0, tx = 1'b0, ti = 1'b0, rtn = 1'b0;
    logic        cfail = 1'b0, wfail = 1'b0, wdis = 1'b1, nmi_n = 1'b1;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdat = 8'h00, rdat, mdat;
    logic [19:0] req = 20'h00000;
    logic [1:0]  stall = 2'h0;
    logic [15:0] maddr, pc, vaddr;
    logic        mrd, pcl, take, tok, xf, ifl;
    int          err_total = 0, total_checks = 0;
    logic [31:0] seed = 32'h26AB8B91;

    mipv_ctrl dut
    (
        .clock_i(clk), .resetn_i(rst_n), .addr_i(addr), .wdata_i(wdat),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .instr_boundary_i(bnd),
        .soft_trap_instr_i(trap), .illegal_opcode_i(ill),
        .ccr_stacked_i(condition_code_reg), .tap_i(tap), .tap_x_i(tx), .tap_i_flag_i(ti),
        .return_from_trap_instr_i(rtn), .rtn_x_i(tx), .rtn_i_flag_i(ti),
        .clock_fail_i(cfail), .watchdog_fail_i(wfail),
        .watchdog_disable_cfg_i(wdis), .pseudo_nmi_pin_n_i(nmi_n),
        .irq_pin_n_i(~req[14]), .handshake_req_i(req[0]),
        .periodic_req_i(req[1]), .capture_req_i(req[4:2]),
        .compare_req_i(req[9:5]), .timer_wrap_req_i(req[10]),
        .pulse_overflow_req_i(req[11]), .pulse_edge_req_i(req[12]),
        .serial_periph_req_i(req[13]), .rx_full_req_i(req[15]),
        .rx_overrun_req_i(req[16]), .idle_line_req_i(req[17]),
        .tx_empty_req_i(req[18]), .tx_done_req_i(req[19]),
        .mem_data_i(mdat), .mem_addr_o(maddr), .mem_rd_o(mrd), .pc_o(pc),
        .pc_load_o(pcl), .take_o(take), .vector_addr_o(vaddr),
        .trap_fetch_ok_o(tok), .x_flag_o(xf), .i_flag_o(ifl)
    );
    mipv_core_model core
    (
        .clock_i(clk), .resetn_i(rst_n), .take_i(take), .mem_rd_i(mrd),
        .mem_addr_i(maddr), .stall_i(stall), .ccr_stacked_o(condition_code_reg),
        .mem_data_o(mdat)
    );

    initial
    begin
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [15:0] pcx(input logic [15:0] v);
        return {v[7:0] ^ 8'h5A, (v[7:0] + 8'h01) ^ 8'h5A};
    endfunction
    // Vector, enable offset and enable mask of source k
    function automatic logic [26:0] src(input int k);
        if (k == 14) return {16'hFFF2, 3'h7, 8'h00};
        if (k == 0) return {16'hFFF2, 3'h2, 8'h20};
        if (k == 1) return {16'hFFF0, 3'h2, 8'h10};
        if (k < 10)
            return {16'hFFEE - 16'(2 * (k - 2)), 3'h3, 8'h01 << (k - 2)};
        if (k < 14)
            return {16'hFFDE - 16'(2 * (k - 10)), 3'h2, 8'h01 << (k - 10)};
        if (k < 17) return {16'hFFD6, 3'h4, 8'h01};
        return {16'hFFD6, 3'h4, 8'h01 << (k - 16)};
    endfunction
    function automatic logic [15:0] pvec(input logic [3:0] c);
        if (c < 4'h4) return 16'hFFDE - {11'h0, c, 1'b0};
        if (c == 4'h4) return 16'hFFD6;
        if (c < 4'h7) return 16'hFFF2;
        if (c == 4'h7) return 16'hFFF0;
        return 16'hFFEE - {11'h0, c - 4'h8, 1'b0};
    endfunction

    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic chkreg(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK("register", e, rdat)
    endtask
    // r selects return from trap, else transfer to flags
    task automatic fl(input bit r, input logic x, input logic i);
        @(posedge clk);
        rtn <= r;
        tap <= !r;
        tx <= x;
        ti <= i;
        @(posedge clk);
        {rtn, tap} <= 2'b00;
        #1;
    endtask
    task automatic pulse(input int s);
        @(posedge clk);
        bnd <= (s == 0);
        trap <= (s == 1);
        ill <= (s == 2);
        cfail <= (s == 3);
        wfail <= (s == 4);
        @(posedge clk);
        {bnd, trap, ill, cfail, wfail} <= 5'h00;
        #1;
    endtask
    task automatic wait_ev(input int s, input int n, input bit must,
                           output bit got);
        repeat (n)
        begin
            got = ((s == 0 ? take : s == 1 ? pcl : tok) === 1'b1);
            if (got)
                return;
            @(posedge clk);
            #1;
        end
        if (must)
        begin
            err_total++;
            $display("ERROR wait exp 1 got 0");
            report_and_stop;
        end
    endtask
    task automatic serve(input logic [15:0] v, input logic ex, input bit fc);
        bit got;
        wait_ev(0, 8, 1, got);
        `CHK("vector", v, vaddr)
        wait_ev(1, 20, 1, got);
        `CHK("pc", pcx(v), pc)
        if (fc)
        begin
            `CHK("x flag", ex, xf)
            `CHK("i flag", 1'b1, ifl)
        end
        @(posedge clk);
    endtask

    initial
    begin
        bit got;
        int k1, k2;
        logic [3:0] c;
        logic [15:0] v;
        logic [26:0] s;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wait_ev(1, 10, 1, got);
        `CHK("reset pc", pcx(16'hFFFE), pc)
        `CHK("x reset", 1'b1, xf)
        `CHK("i reset", 1'b1, ifl)
        chkreg(3'h0, 8'h05);
        chkreg(3'h1, 8'h00);
        chkreg(3'h5, 8'h03);
        wreg(3'h1, 8'hFF);
        chkreg(3'h1, 8'h01);
        wreg(3'h6, 8'hFF);
        chkreg(3'h6, 8'h00);
        wreg(3'h0, 8'h0A);
        chkreg(3'h0, 8'h0A);
        fl(0, 1'b1, 1'b0);
        for (int k = 0; k < 20; k++)
        begin
            s = src(k);
            for (int a = 2; a < 5; a++) wreg(3'(a), 8'h00);
            @(posedge clk);
            req <= 20'h1 << k;
            wait_ev(0, 4, 0, got);
            `CHK("early take", 1'b0, got)
            pulse(0);
            wait_ev(0, 4, 0, got);
            `CHK("local gate", k == 14, got)
            if (got)
                serve(s[26:11], 1'b1, 1'b0);
            if (got)
                fl(1, 1'b1, 1'b0);
            wreg(s[10:8], s[7:0]);
            fl(0, 1'b1, 1'b1);
            pulse(0);
            wait_ev(0, 4, 0, got);
            `CHK("i gate", 1'b0, got)
            fl(0, 1'b1, 1'b0);
            pulse(0);
            serve(s[26:11], 1'b1, 1'b1);
            @(posedge clk);
            req <= 20'h0;
            fl(1, 1'b1, 1'b0);
            `CHK("x restore", 1'b1, xf)
            `CHK("i restore", 1'b0, ifl)
        end
        fl(0, 1'b0, 1'b0);
        fl(0, 1'b1, 1'b0);
        `CHK("x stays clear", 1'b0, xf)
        for (int a = 2; a < 5; a++) wreg(3'(a), 8'hFF);
        for (int n = 0; n < 32; n++)
        begin
            seed = xs(seed);
            k1 = seed[4:0] % 20;
            k2 = seed[9:5] % 20;
            c = seed[13:10];
            fl(0, 1'b0, 1'b1);
            wreg(3'h0, {4'h0, c});
            chkreg(3'h0, {4'h0, c});
            fl(0, 1'b0, 1'b0);
            wreg(3'h0, {4'h0, ~c});
            chkreg(3'h0, {4'h0, c});
            v = 16'(src(k1) > src(k2) ? src(k1) >> 11 : src(k2) >> 11);
            if (src(k1) >> 11 == pvec(c) || src(k2) >> 11 == pvec(c))
                v = pvec(c);
            v = seed[16] ? 16'hFFF8 : seed[17] ? 16'hFFF4 : v;
            @(posedge clk);
            req <= (20'h1 << k1) | (20'h1 << k2);
            nmi_n <= !seed[17];
            stall <= seed[19:18];
            if (seed[16])
                pulse(2);
            pulse(0);
            serve(v, seed[17], !seed[16]);
            @(posedge clk);
            req <= 20'h0;
            nmi_n <= 1'b1;
            fl(1, 1'b0, 1'b0);
        end
        @(posedge clk);
        req <= 20'h1 << 14;
        wait_ev(0, 3, 0, got);
        `CHK("trap held off", 1'b0, tok)
        @(posedge clk);
        req <= 20'h0;
        wait_ev(2, 8, 1, got);
        pulse(1);
        wait_ev(0, 4, 1, got);
        `CHK("trap vector", 16'hFFF6, vaddr)
        @(posedge clk);
        nmi_n <= 1'b0;
        pulse(0);
        wait_ev(0, 2, 0, got);
        `CHK("trap blocks", 1'b0, got)
        wait_ev(1, 20, 1, got);
        `CHK("trap pc", pcx(16'hFFF6), pc)
        pulse(0);
        serve(16'hFFF4, 1'b1, 1'b1);
        nmi_n <= 1'b1;
        wreg(3'h1, 8'h00);
        pulse(3);
        pulse(4);
        wait_ev(1, 8, 0, got);
        `CHK("gated reset", 1'b0, got)
        wreg(3'h1, 8'h01);
        pulse(3);
        wait_ev(1, 12, 1, got);
        `CHK("monitor pc", pcx(16'hFFFC), pc)
        `CHK("x again", 1'b1, xf)
        chkreg(3'h1, 8'h00);
        chkreg(3'h0, 8'h05);
        @(posedge clk);
        wdis <= 1'b0;
        pulse(4);
        wait_ev(1, 12, 1, got);
        `CHK("watchdog pc", pcx(16'hFFFA), pc)
        report_and_stop;
    end
endmodule
